// File: pcl_pkg.sv
package pcl_pkg;

    localparam int          PCL_DATA_W       = 32;

    // byte addresses on the configuration bus
    localparam logic [31:0] PCL_SELECT_ADDR  = 32'h01B3_F000;
    localparam logic [31:0] PCL_LOCK_ADDR    = 32'h01B3_F018;

    // peripheral_select field positions
    localparam int          PCL_AUDIO_BIT    = 0;
    localparam int          PCL_SERIAL0_BIT  = 1;
    localparam int          PCL_SERIAL1_BIT  = 2;
    localparam int          PCL_I2C_BIT      = 3;
    localparam int          PCL_VIDEO0_BIT   = 4;
    localparam int          PCL_VIDEO1_BIT   = 5;

    localparam logic [31:0] PCL_SELECT_RESET = 32'h0000_0006;
    localparam logic [31:0] PCL_SELECT_WMASK = 32'h0000_007F;

    // peripheral_lock
    localparam int          PCL_LOCK_BIT     = 0;
    localparam logic [31:0] PCL_LOCK_KEY     = 32'h10C0_010C;

    // cycles from an accepted select write to the register update
    localparam int          PCL_POST_LATENCY = 2;

    typedef enum logic {
        PCL_ST_LOCKED,
        PCL_ST_UNLOCKED
    } pcl_lock_state_t;

endpackage : pcl_pkg

// File: pcl_lock.sv
`timescale 1ns/100ps
module pcl_lock (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_key_write,
    input  wire logic [31:0] i_key_data,
    input  wire logic        i_relock,
    output logic             o_lock_status
);
    import pcl_pkg::*;

    pcl_lock_state_t state;
    pcl_lock_state_t next_state;

    always_comb begin
        next_state = state;
        // relock wins so an accepted select write can never leave it open
        if (i_relock) begin
            next_state = PCL_ST_LOCKED;
        end else if (i_key_write && (i_key_data == PCL_LOCK_KEY)) begin
            next_state = PCL_ST_UNLOCKED;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= PCL_ST_LOCKED;
        end else begin
            state <= next_state;
        end
    end

    assign o_lock_status = (state == PCL_ST_LOCKED);

endmodule : pcl_lock

// File: pcl_write_post.sv
`timescale 1ns/100ps
module pcl_write_post #(
    parameter int LATENCY = pcl_pkg::PCL_POST_LATENCY
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wr_valid,
    input  wire logic [31:0] i_wr_data,
    output logic             o_busy,
    output logic             o_apply,
    output logic [31:0]      o_apply_data
);
    import pcl_pkg::*;

    localparam int CW = $clog2(LATENCY + 1);

    if (LATENCY < 1 || LATENCY > 255) begin : g_bad_latency
        $error("pcl_write_post: LATENCY must be 1..255");
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [31:0]   data;
    logic [31:0]   next_data;

    always_comb begin
        next_count = count;
        next_data  = data;
        // only one write in flight; the bus stalls further select accesses
        if (i_wr_valid && (count == '0)) begin
            next_count = CW'(LATENCY);
            next_data  = i_wr_data;
        end else if (count != '0) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count <= '0;
            data  <= 32'h0000_0000;
        end else begin
            count <= next_count;
            data  <= next_data;
        end
    end

    assign o_busy       = (count != '0);
    assign o_apply      = (count == CW'(1));
    assign o_apply_data = data;

endmodule : pcl_write_post

// File: pcl_config_lock.sv
`timescale 1ns/100ps
module pcl_config_lock #(
    parameter int POST_DELAY = pcl_pkg::PCL_POST_LATENCY
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_cfg_req,
    input  wire logic        i_cfg_we,
    input  wire logic [31:0] i_cfg_addr,
    input  wire logic [31:0] i_cfg_wdata,
    output logic             o_cfg_ready,
    output logic             o_cfg_rvalid,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_audio_port_en,
    output logic             o_serial_port0_en,
    output logic             o_serial_port1_en,
    output logic             o_i2c_en,
    output logic             o_video_port0_en,
    output logic             o_video_port1_en,
    output logic             o_video_port0_lower_en,
    output logic             o_video_port1_lower_en,
    output logic             o_video_port0_upper_en,
    output logic             o_video_port1_upper_en
);
    import pcl_pkg::*;

    if (POST_DELAY < 1 || POST_DELAY > 255) begin : g_bad_delay
        $error("pcl_config_lock: POST_DELAY must be 1..255");
    end

    function automatic logic pcl_addr_hit(input logic [31:0] addr, input logic [31:0] target);
        return (addr == target);
    endfunction : pcl_addr_hit

    // pin steering; bit 0 (audio) at 0 is the audio-off mode that keeps video upper pins
    function automatic logic [9:0] pcl_pin_map(input logic [31:0] sel);
        logic [9:0] p;
        p    = '0;
        p[0] = sel[PCL_AUDIO_BIT];
        p[1] = sel[PCL_SERIAL0_BIT];
        p[2] = sel[PCL_SERIAL1_BIT];
        p[3] = sel[PCL_I2C_BIT];
        p[4] = sel[PCL_VIDEO0_BIT];
        p[5] = sel[PCL_VIDEO1_BIT];
        p[6] = sel[PCL_VIDEO0_BIT] && !sel[PCL_SERIAL0_BIT];
        p[7] = sel[PCL_VIDEO1_BIT] && !sel[PCL_SERIAL1_BIT];
        p[8] = sel[PCL_VIDEO0_BIT] && !sel[PCL_AUDIO_BIT];
        p[9] = sel[PCL_VIDEO1_BIT] && !sel[PCL_AUDIO_BIT];
        return p;
    endfunction : pcl_pin_map

    // pins leave reset already matching the reset select value, no glitch at release
    localparam logic [9:0] PINS_RESET = pcl_pin_map(PCL_SELECT_RESET);

    logic        hit_select;
    logic        hit_lock;
    logic        take;
    logic        select_write_ok;
    logic        key_write;
    logic        lock_status;
    logic        post_busy;
    logic        post_apply;
    logic [31:0] post_data;

    logic [31:0] select;
    logic [31:0] next_select;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [9:0]  pins;
    logic [9:0]  next_pins;

    assign hit_select = pcl_addr_hit(i_cfg_addr, PCL_SELECT_ADDR);
    assign hit_lock   = pcl_addr_hit(i_cfg_addr, PCL_LOCK_ADDR);

    // any select access waits while a posted write is still in flight
    assign o_cfg_ready     = !(i_cfg_req && hit_select && post_busy);
    assign take            = i_cfg_req && o_cfg_ready;
    assign select_write_ok = take && i_cfg_we && hit_select && !lock_status;
    assign key_write       = take && i_cfg_we && hit_lock;

    pcl_lock u_lock (
        .i_clk_sys     (i_clk_sys),
        .i_sys_rst     (i_sys_rst),
        .i_key_write   (key_write),
        .i_key_data    (i_cfg_wdata),
        .i_relock      (select_write_ok),
        .o_lock_status (lock_status)
    );

    // select writes are posted, matching the bus's decoupled write path
    pcl_write_post #(
        .LATENCY (POST_DELAY)
    ) u_post (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_wr_valid   (select_write_ok),
        .i_wr_data    (i_cfg_wdata & PCL_SELECT_WMASK),
        .o_busy       (post_busy),
        .o_apply      (post_apply),
        .o_apply_data (post_data)
    );

    always_comb begin
        next_select = select;
        if (post_apply) begin
            next_select = post_data;
        end
    end

    always_comb begin
        next_rvalid = take && !i_cfg_we;
        next_rdata  = o_cfg_rdata;
        if (take && !i_cfg_we) begin
            if (hit_select) begin
                next_rdata = select;
            end else if (hit_lock) begin
                next_rdata = {31'h0000_0000, lock_status};
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    always_comb begin
        next_pins = pcl_pin_map(select);
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            select       <= PCL_SELECT_RESET;
            o_cfg_rvalid <= 1'b0;
            o_cfg_rdata  <= 32'h0000_0000;
            pins         <= PINS_RESET;
        end else begin
            select       <= next_select;
            o_cfg_rvalid <= next_rvalid;
            o_cfg_rdata  <= next_rdata;
            pins         <= next_pins;
        end
    end

    assign o_audio_port_en        = pins[0];
    assign o_serial_port0_en      = pins[1];
    assign o_serial_port1_en      = pins[2];
    assign o_i2c_en               = pins[3];
    assign o_video_port0_en       = pins[4];
    assign o_video_port1_en       = pins[5];
    assign o_video_port0_lower_en = pins[6];
    assign o_video_port1_lower_en = pins[7];
    assign o_video_port0_upper_en = pins[8];
    assign o_video_port1_upper_en = pins[9];

    // assertion helper: length of the current run of stalled accesses, saturating
    localparam int STALL_W = $clog2(POST_DELAY + 2);

    logic [STALL_W-1:0] stall_run;
    logic [STALL_W-1:0] next_stall_run;

    always_comb begin
        next_stall_run = '0;
        if (i_cfg_req && !o_cfg_ready && (stall_run != '1)) begin
            next_stall_run = stall_run + STALL_W'(1);
        end else if (i_cfg_req && !o_cfg_ready) begin
            next_stall_run = stall_run;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stall_run <= '0;
        end else begin
            stall_run <= next_stall_run;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    chk_locked_write_kept: assert property (
        (take && i_cfg_we && hit_select && lock_status) |=> $stable(select) && !post_busy)
        else $error("select changed after a locked write");

    chk_write_lands: assert property (
        select_write_ok |=> ##POST_DELAY
            (select == ($past(i_cfg_wdata, POST_DELAY + 1) & PCL_SELECT_WMASK)))
        else $error("select write did not land on time");

    chk_read_stalls: assert property (
        (i_cfg_req && hit_select && post_busy) |-> !o_cfg_ready)
        else $error("select access not stalled during posted write");

    chk_relock_write: assert property (
        select_write_ok |=> lock_status)
        else $error("lock not restored after select write");

    chk_key_unlocks: assert property (
        (key_write && (i_cfg_wdata == PCL_LOCK_KEY) && !select_write_ok) |=> !lock_status)
        else $error("key did not unlock");

    chk_bad_key_kept: assert property (
        (key_write && (i_cfg_wdata != PCL_LOCK_KEY)) |=> $stable(lock_status))
        else $error("wrong key changed lock status");

    chk_lock_read_view: assert property (
        (take && !i_cfg_we && hit_lock) |=>
            o_cfg_rvalid && (o_cfg_rdata == {31'h0000_0000, $past(lock_status)}))
        else $error("lock read view wrong");

    chk_select_read_view: assert property (
        (take && !i_cfg_we && hit_select) |=> o_cfg_rvalid && (o_cfg_rdata == $past(select)))
        else $error("select read view wrong");

    chk_serial0_lower: assert property (
        o_serial_port0_en |-> !o_video_port0_lower_en)
        else $error("serial port 0 and video 0 lower pins both on");

    chk_audio_upper: assert property (
        o_audio_port_en |-> !o_video_port0_upper_en && !o_video_port1_upper_en)
        else $error("audio port and video upper pins both on");

    chk_video_powerdown: assert property (
        !select[PCL_VIDEO0_BIT] ##1 !select[PCL_VIDEO0_BIT] |-> !o_video_port0_en)
        else $error("video port 0 enabled while its bit is clear");

    chk_ready_free: assert property (
        !(i_cfg_req && hit_select && post_busy) |-> o_cfg_ready)
        else $error("access stalled with no posted write pending");

    chk_stall_bounded: assert property (
        stall_run <= STALL_W'(POST_DELAY))
        else $error("select access stalled longer than the post delay");

    chk_rvalid_only_read: assert property (
        !(take && !i_cfg_we) |=> !o_cfg_rvalid)
        else $error("read valid without a taken read");

    chk_lock_high_zero: assert property (
        (take && !i_cfg_we && hit_lock) |=> (o_cfg_rdata[PCL_DATA_W-1:PCL_LOCK_BIT+1] == '0))
        else $error("lock read shows nonzero upper bits");

    chk_unlock_by_key: assert property (
        $fell(lock_status) |-> $past(key_write && (i_cfg_wdata == PCL_LOCK_KEY)))
        else $error("lock opened without the key");

    chk_relock_by_write: assert property (
        $rose(lock_status) |-> $past(select_write_ok))
        else $error("lock closed without a select write");

    chk_serial1_lower: assert property (
        o_serial_port1_en |-> !o_video_port1_lower_en)
        else $error("serial port 1 and video 1 lower pins both on");

    chk_enable_follow: assert property (
        {o_video_port1_en, o_video_port0_en, o_i2c_en} == $past(select[PCL_VIDEO1_BIT:PCL_I2C_BIT]))
        else $error("peripheral enables do not follow select");

    chk_serial_follow: assert property (
        {o_serial_port1_en, o_serial_port0_en} == $past(select[PCL_SERIAL1_BIT:PCL_SERIAL0_BIT]))
        else $error("serial port enables do not follow select");

    chk_audio_follow: assert property (
        o_audio_port_en == $past(select[PCL_AUDIO_BIT]))
        else $error("audio port enable does not follow select");

    chk_lower_follow: assert property (
        {o_video_port1_lower_en, o_video_port0_lower_en} ==
            $past({select[PCL_VIDEO1_BIT] && !select[PCL_SERIAL1_BIT],
                   select[PCL_VIDEO0_BIT] && !select[PCL_SERIAL0_BIT]}))
        else $error("video lower pins do not follow select");

    chk_upper_follow: assert property (
        {o_video_port1_upper_en, o_video_port0_upper_en} ==
            $past({select[PCL_VIDEO1_BIT] && !select[PCL_AUDIO_BIT],
                   select[PCL_VIDEO0_BIT] && !select[PCL_AUDIO_BIT]}))
        else $error("video upper pins do not follow select");

    cov_unlock: cover property (key_write && (i_cfg_wdata == PCL_LOCK_KEY) ##1 !lock_status);
    cov_select_write: cover property (select_write_ok ##1 post_busy ##POST_DELAY !post_busy);
    cov_relock: cover property ($rose(lock_status));
    cov_stalled_read: cover property (i_cfg_req && !i_cfg_we && hit_select && !o_cfg_ready);
    cov_locked_write: cover property (take && i_cfg_we && hit_select && lock_status);

endmodule : pcl_config_lock

// File: pcl_config_lock_tb.sv
`timescale 1ns/100ps
module pcl_config_lock_tb;
    import pcl_pkg::*;

    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        cfg_req   = 1'b0;
    logic        cfg_we    = 1'b0;
    logic [31:0] cfg_addr  = 32'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic        cfg_ready;
    logic        cfg_rvalid;
    logic [31:0] cfg_rdata;
    logic [9:0]  pins;
    int          num_errors = 0;
    int          checks     = 0;
    int          stalls     = 0;
    int          cycles     = 0;

    localparam int ENABLE_WAIT = 128;

    always #2 clk_sys = ~clk_sys;

    pcl_config_lock pcl_config_lock_i (
        .i_clk_sys              (clk_sys),
        .i_sys_rst              (sys_rst),
        .i_cfg_req              (cfg_req),
        .i_cfg_we               (cfg_we),
        .i_cfg_addr             (cfg_addr),
        .i_cfg_wdata            (cfg_wdata),
        .o_cfg_ready            (cfg_ready),
        .o_cfg_rvalid           (cfg_rvalid),
        .o_cfg_rdata            (cfg_rdata),
        .o_audio_port_en        (pins[0]),
        .o_serial_port0_en      (pins[1]),
        .o_serial_port1_en      (pins[2]),
        .o_i2c_en               (pins[3]),
        .o_video_port0_en       (pins[4]),
        .o_video_port1_en       (pins[5]),
        .o_video_port0_lower_en (pins[6]),
        .o_video_port1_lower_en (pins[7]),
        .o_video_port0_upper_en (pins[8]),
        .o_video_port1_upper_en (pins[9])
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // generous ceiling; the whole sequence needs about eight hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] exp_pins(input logic [31:0] s);
        return {22'h0, s[5] & ~s[0], s[4] & ~s[0], s[5] & ~s[2], s[4] & ~s[1], s[5:0]};
    endfunction : exp_pins

    // request held from one rising edge until the edge where ready is high
    task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        rd = 32'h0;
        @(posedge clk_sys);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_wdata <= wd;
        @(negedge clk_sys);
        while (cfg_ready !== 1'b1 && n < 10) begin
            n++;
            stalls++;
            @(negedge clk_sys);
        end
        chk("ready_wait_ok", {31'h0, n < 10}, 32'h1);
        @(posedge clk_sys);
        cfg_req <= 1'b0;
        if (!we) begin
            @(negedge clk_sys);
            chk("rvalid", {31'h0, cfg_rvalid}, 32'h1);
            rd = cfg_rdata;
        end
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(name, d, exp);
    endtask : rd_chk

    // mid-run reset; select and the pin mux choice go back to their reset values
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        chk("pins_after_reset", {22'h0, pins}, exp_pins(PCL_SELECT_RESET));
        chk("rvalid_after_reset", {31'h0, cfg_rvalid}, 32'h0);
        @(negedge clk_sys);
        chk("pins_after_reset2", {22'h0, pins}, exp_pins(PCL_SELECT_RESET));
    endtask : do_reset

    task automatic test_reset();
        rd_chk("select_reset", PCL_SELECT_ADDR, PCL_SELECT_RESET);
        rd_chk("lock_reset", PCL_LOCK_ADDR, 32'h1);
        chk("pins_reset", {22'h0, pins}, exp_pins(PCL_SELECT_RESET));
        $display("test reset done");
    endtask : test_reset

    task automatic test_locked();
        wr(PCL_SELECT_ADDR, 32'h0000_003B);
        rd_chk("select_locked", PCL_SELECT_ADDR, PCL_SELECT_RESET);
        wr(PCL_LOCK_ADDR, 32'h10C0_010D);
        rd_chk("lock_near_key", PCL_LOCK_ADDR, 32'h1);
        wr(PCL_LOCK_ADDR, 32'hFFFF_FFFE);
        rd_chk("lock_high_bits", PCL_LOCK_ADDR, 32'h1);
        chk("pins_locked", {22'h0, pins}, exp_pins(PCL_SELECT_RESET));
        $display("test locked done");
    endtask : test_locked

    task automatic test_unlock();
        wr(PCL_LOCK_ADDR, PCL_LOCK_KEY);
        rd_chk("lock_open", PCL_LOCK_ADDR, 32'h0);
        wr(PCL_LOCK_ADDR, 32'hFFFF_FFFE);
        rd_chk("lock_open_kept", PCL_LOCK_ADDR, 32'h0);
        $display("test unlock done");
    endtask : test_unlock

    task automatic test_enables();
        logic [31:0] vals [5];
        int          s0;
        // bit 0 set in every value, each one the whole enable set in a single write
        vals = '{32'h0000_003B, 32'h0000_0035, 32'h0000_0039, 32'h0000_0007, 32'hFFFF_FFFF};
        foreach (vals[k]) begin
            do_reset();
            wr(PCL_LOCK_ADDR, PCL_LOCK_KEY);
            wr(PCL_SELECT_ADDR, vals[k]);
            s0 = stalls;
            rd_chk("select_back", PCL_SELECT_ADDR, vals[k] & PCL_SELECT_WMASK);
            chk("select_stall", {31'h0, stalls > s0}, 32'h1);
            rd_chk("lock_relock", PCL_LOCK_ADDR, 32'h1);
            repeat (ENABLE_WAIT) @(negedge clk_sys);
            chk("pins", {22'h0, pins}, exp_pins(vals[k]));
        end
        // turn video ports and i2c off; mux bits 2:0 stay as they are
        wr(PCL_LOCK_ADDR, PCL_LOCK_KEY);
        wr(PCL_SELECT_ADDR, 32'h0000_0047);
        rd_chk("select_off", PCL_SELECT_ADDR, 32'h0000_0047);
        chk("pins_off", {22'h0, pins}, exp_pins(32'h0000_0047));
        $display("test enables done");
    endtask : test_enables

    task automatic test_unmapped();
        do_reset();
        wr(PCL_LOCK_ADDR, PCL_LOCK_KEY);
        wr(32'h01B3_F100, 32'hFFFF_FFFF);
        rd_chk("unmapped_read", 32'h01B3_F100, 32'h0);
        rd_chk("select_kept", PCL_SELECT_ADDR, PCL_SELECT_RESET);
        rd_chk("lock_kept", PCL_LOCK_ADDR, 32'h0);
        $display("test unmapped done");
    endtask : test_unmapped

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        test_reset();
        test_locked();
        test_unlock();
        test_enables();
        test_unmapped();
        stop_test();
    end

endmodule : pcl_config_lock_tb
